/* File: common/prog_ctl_pkg.sv */
// Purpose: Constants and types shared by the program fetch and address file design.
// Assumes: 20-bit addresses, 48-bit code words holding six 8-bit syllables.
// Notes:   Contract list below names each behaviour required of the design.
//
// Contract
// [RQ1] Execute syllables only while code word valid
// [RQ2] Syllable pointer selects next syllable executed
// [RQ3] Controller decides execution, reloads and source
// [RQ4] Look-ahead fetches next word; flag marks occupied
// [RQ5] First fetch base plus offset, then lookahead address
// [RQ6] Branch or call/return restarts fetch at new address
// [RQ7] Table mode: no look-ahead, table base plus index
// [RQ8] Table index steps through table code
// [RQ9] Thirty-two display registers hold frame marker bases
// [RQ10] Software uses at most thirty levels
// [RQ11] Eight numbered base registers
// [RQ12] Index registers zero to four defined
// [RQ13] Index registers five to seven defined
// [RQ14] String addresses are base plus index
// [RQ15] Table index free as temporary store
// [RQ16] Stack upper limit confines stack growth; the design only raises STACK_OVERFLOW when the stack top exceeds it
// [RQ17] Stack number indexes stack vector descriptor
// [RQ18] Frame marker register equals current level display
// [RQ19] 960 storage bits, 20-bit adder, 3-bit residue; the design stores a 2-bit modulo-three residue
// [RQ20] Residue error raises fatal abort
// [RQ21] Exhausted word takes occupied look-ahead word
// [RQ22] Branch clears both valid flags before refetch
package prog_ctl_pkg;
  localparam int ADDR_W      = 20;
  localparam int RES_W       = 2;
  localparam int WORD_W      = 48;
  localparam int SYL_W       = 8;
  localparam int SYL_N       = 6;
  localparam int REG_N       = 48;
  localparam int IDX_W       = 6;
  localparam int DISPLAY_N   = 32;
  localparam int STORE_BITS  = 960;
  localparam logic [2:0] LAST_SYL = 3'h5;

  // File layout: displays 0..31, bases 32..39, indexes 40..47.
  localparam logic [IDX_W-1:0] BASE_OFS  = 6'h20;
  localparam logic [IDX_W-1:0] INDEX_OFS = 6'h28;
  localparam logic [2:0] CODE_SEGMENT_BASE  = 3'h0;
  localparam logic [2:0] SOURCE_STRING_BASE = 3'h1;
  localparam logic [2:0] DEST_STRING_BASE   = 3'h2;
  localparam logic [2:0] TABLE_CODE_BASE    = 3'h3;
  localparam logic [2:0] STACK_TOP_ADDR     = 3'h4;
  localparam logic [2:0] STACK_NUMBER_REG   = 3'h5;
  localparam logic [2:0] CODE_DICT_BASE     = 3'h6;
  localparam logic [2:0] SCRATCH_BASE       = 3'h7;
  localparam logic [2:0] CODE_OFFSET_INDEX  = 3'h0;
  localparam logic [2:0] SOURCE_STRING_IDX  = 3'h1;
  localparam logic [2:0] DEST_STRING_IDX    = 3'h2;
  localparam logic [2:0] TABLE_CODE_INDEX   = 3'h3;
  localparam logic [2:0] STACK_UPPER_LIMIT  = 3'h4;
  localparam logic [2:0] STACK_LOWER_LIMIT  = 3'h5;
  localparam logic [2:0] FRAME_MARKER_ADDR  = 3'h6;
  localparam logic [2:0] SPARE_ADDRESS      = 3'h7;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
  localparam logic [ADDR_W-1:0] ADDR_ONE   = 20'h00001;
  localparam logic [RES_W-1:0]  RES_RESET  = 2'h0;

  typedef enum logic [1:0] {
    F_IDLE  = 2'b00,
    F_FETCH = 2'b01,
    F_WAIT  = 2'b11
  } fetch_e;

  // Residue modulo three of a 20-bit value.
  function automatic logic [RES_W-1:0] mod3(input logic [ADDR_W-1:0] v);
    logic [5:0] acc;
    acc = 6'h00;
    for (int i = 0; i < ADDR_W; i += 2) begin
      acc = acc + 6'(v[i]) + 6'({v[i+1], 1'b0});
    end
    return 2'(acc % 6'h03);
  endfunction

  // Residue modulo three of the sum of two residues.
  function automatic logic [RES_W-1:0] res_add(input logic [RES_W-1:0] a, input logic [RES_W-1:0] b);
    logic [2:0] s;
    s = 3'(a) + 3'(b);
    return 2'(s % 3'h3);
  endfunction
endpackage

/* File: verilog/addr_adder.sv */
// Purpose: Shared 20-bit address adder with a modulo-three residue adder.
// Assumes: Operand residues arrive with the operands, from the register file or, for look-ahead fetches, computed by the caller.
// Notes:   Combinational; the caller registers the result and error.
module addr_adder
  import prog_ctl_pkg::*;
(
  input  wire logic [ADDR_W-1:0] a,
  input  wire logic [RES_W-1:0]  a_res,
  input  wire logic [ADDR_W-1:0] b,
  input  wire logic [RES_W-1:0]  b_res,
  output logic      [ADDR_W-1:0] sum,
  output logic      [RES_W-1:0]  sum_res,
  output logic                   err
);
  logic [ADDR_W:0] full;

  always_comb begin
    full    = {1'b0, a} + {1'b0, b};
    sum     = full[ADDR_W-1:0];
    // The carry out drops 2^20, whose residue is 1; remove it before comparing.
    sum_res = res_add(res_add(a_res, b_res), full[ADDR_W] ? 2'h2 : 2'h0); // [RQ19]
    // Operand checks catch storage errors, the sum check catches adder errors.
    err     = (mod3(a) != a_res) || (mod3(b) != b_res) || (mod3(sum) != sum_res); // [RQ20]
  end
endmodule

/* File: verilog/addr_reg_file.sv */
// Purpose: Forty-eight 20-bit address registers, each with a stored residue.
// Assumes: One write port and four read ports.
// Notes:   Residue is generated on write so a later read can be checked.
module addr_reg_file
  import prog_ctl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              we,
  input  wire logic [IDX_W-1:0]  wa,
  input  wire logic [ADDR_W-1:0] wd,
  input  wire logic [IDX_W-1:0]  ra0,
  input  wire logic [IDX_W-1:0]  ra1,
  input  wire logic [IDX_W-1:0]  ra2,
  input  wire logic [IDX_W-1:0]  ra3,
  output logic      [ADDR_W-1:0] rd0,
  output logic      [RES_W-1:0]  rr0,
  output logic      [ADDR_W-1:0] rd1,
  output logic      [RES_W-1:0]  rr1,
  output logic      [ADDR_W-1:0] rd2,
  output logic      [ADDR_W-1:0] rd3
);
  typedef struct packed {
    logic [REG_N-1:0][ADDR_W-1:0] val; // 48 x 20 = 960 bits
    logic [REG_N-1:0][RES_W-1:0]  res;
  } file_s;

  file_s s_q;
  file_s s_d;

  always_comb begin
    s_d = s_q;
    if (we) begin
      s_d.val[wa] = wd; // [RQ19]
      s_d.res[wa] = mod3(wd);
    end
    rd0 = s_q.val[ra0];
    rr0 = s_q.res[ra0];
    rd1 = s_q.val[ra1];
    rr1 = s_q.res[ra1];
    rd2 = s_q.val[ra2];
    // The fourth port serves the display of the present lexical level.
    rd3 = s_q.val[ra3]; // [RQ9]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* File: verilog/prog_fetch_ctl.sv */
// Purpose: Program controller: current and look-ahead code words, syllable
//          pointer, code fetch addressing and the address register file.
// Assumes: Memory answers one read at a time with MEM_RD_ACK; operator logic
//          consumes a syllable when SYL_VALID and SYL_TAKE are both high.
// Notes:   The register file is shared; operator logic writes it through
//          the AR_* port when the controller does not need the write port.
module prog_fetch_ctl
  import prog_ctl_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST,
  // Operator logic side.
  input  wire logic              SYL_TAKE,
  input  wire logic              RESTART,
  input  wire logic [ADDR_W-1:0] RESTART_BASE,
  input  wire logic [ADDR_W-1:0] RESTART_INDEX,
  input  wire logic [2:0]        RESTART_SYL,
  input  wire logic              TABLE_MODE,
  input  wire logic              AR_WE,
  input  wire logic [IDX_W-1:0]  AR_WA,
  input  wire logic [ADDR_W-1:0] AR_WD,
  input  wire logic [IDX_W-1:0]  AR_RA,
  input  wire logic [4:0]        LEX_LEVEL,
  input  wire logic [2:0]        ADDR_BASE_SEL,
  input  wire logic [2:0]        ADDR_INDEX_SEL,
  input  wire logic              ADDR_REQ,
  output logic                   SYL_VALID,
  output logic      [SYL_W-1:0]  SYL_DATA,
  output logic      [2:0]        SYL_PTR,
  output logic                   CODE_WORD_VALID,
  output logic                   LOOKAHEAD_VALID,
  output logic      [ADDR_W-1:0] AR_RD,
  output logic      [ADDR_W-1:0] ADDR_SUM,
  output logic                   ADDR_SUM_VALID,
  output logic                   STACK_OVERFLOW,
  output logic      [ADDR_W-1:0] FRAME_MARKER,
  output logic                   ABORT,
  // Memory controller side.
  output logic                   MEM_RD_REQ,
  output logic      [ADDR_W-1:0] MEM_RD_ADDR,
  input  wire logic              MEM_RD_ACK,
  input  wire logic [WORD_W-1:0] MEM_RD_DATA
);
  typedef struct packed {
    fetch_e            fst;
    logic [WORD_W-1:0] code_q;
    logic [WORD_W-1:0] look_q;
    logic              code_vld;
    logic              look_vld;
    logic [2:0]        syl_ptr;
    logic [2:0]        restart_syl;
    logic              dest_look;
    logic [ADDR_W-1:0] la_addr;
    logic              table_q;
    logic              syl_vld;
    logic [SYL_W-1:0]  syl_data;
    logic [ADDR_W-1:0] ar_rd;
    logic [ADDR_W-1:0] sum;
    logic              sum_vld;
    logic              ovf;
    logic [ADDR_W-1:0] frame;
    logic              abort;
    logic              req;
    logic [ADDR_W-1:0] req_addr;
    logic              rs_pend;
    logic [ADDR_W-1:0] rs_idx;
    logic [ADDR_W-1:0] top;
    logic [ADDR_W-1:0] lim;
  } ctl_s;

  ctl_s s_q;
  ctl_s s_d;

  logic              fw_we;
  logic [IDX_W-1:0]  fw_wa;
  logic [ADDR_W-1:0] fw_wd;
  logic [IDX_W-1:0]  ra_base;
  logic [IDX_W-1:0]  ra_index;
  logic [ADDR_W-1:0] rd_base;
  logic [RES_W-1:0]  rr_base;
  logic [ADDR_W-1:0] rd_index;
  logic [RES_W-1:0]  rr_index;
  logic [ADDR_W-1:0] rd_misc;
  logic [ADDR_W-1:0] rd_frame;
  logic [ADDR_W-1:0] add_a;
  logic [RES_W-1:0]  add_a_res;
  logic [ADDR_W-1:0] add_b;
  logic [RES_W-1:0]  add_b_res;
  logic [ADDR_W-1:0] add_sum;
  logic [RES_W-1:0]  add_sum_res;
  logic              add_err;
  logic              restart_wr;
  logic              code_fetch;
  logic              tbl_step;

  function automatic logic [IDX_W-1:0] base_idx(input logic [2:0] n);
    return BASE_OFS + IDX_W'(n); // [RQ11]
  endfunction

  // Index numbers 0 to 4 and 5 to 7 map onto the last eight entries.
  function automatic logic [IDX_W-1:0] index_idx(input logic [2:0] n);
    return INDEX_OFS + IDX_W'(n); // [RQ12] [RQ13]
  endfunction

  addr_reg_file u_file (
    .clk (CLK),
    .rst (RST),
    .we  (fw_we),
    .wa  (fw_wa),
    .wd  (fw_wd),
    .ra0 (ra_base),
    .ra1 (ra_index),
    .ra2 (AR_RA),
    .rd0 (rd_base),
    .rr0 (rr_base),
    .rd1 (rd_index),
    .rr1 (rr_index),
    .ra3 (IDX_W'(LEX_LEVEL)),
    .rd2 (rd_misc),
    .rd3 (rd_frame)
  );

  addr_adder u_adder (
    .a       (add_a),
    .a_res   (add_a_res),
    .b       (add_b),
    .b_res   (add_b_res),
    .sum     (add_sum),
    .sum_res (add_sum_res),
    .err     (add_err)
  );

  // ---------------------------------------------------------------------------
  // Address adder steering
  // ---------------------------------------------------------------------------
  always_comb begin
    // A code fetch starts when the fetch engine is idle and a word is wanted.
    // A restart first has to land its new index before a fetch may read it.
    code_fetch = (s_q.fst == F_IDLE) && !RESTART && !s_q.rs_pend &&
                 (!s_q.code_vld || (!s_q.look_vld && !s_q.table_q)); // [RQ3]
    // Table code is addressed through its own base and index pair.
    if (s_q.table_q) begin
      ra_base  = base_idx(TABLE_CODE_BASE); // [RQ7]
      ra_index = index_idx(TABLE_CODE_INDEX);
    end else if (code_fetch) begin
      ra_base  = base_idx(CODE_SEGMENT_BASE); // [RQ5]
      ra_index = index_idx(CODE_OFFSET_INDEX);
    end else begin
      // String words and the stack number on a descriptor base use this pair.
      // [RQ14] [RQ17]
      ra_base  = base_idx(ADDR_BASE_SEL);
      ra_index = index_idx(ADDR_INDEX_SEL);
    end
    add_a     = rd_base;
    add_a_res = rr_base;
    add_b     = rd_index;
    add_b_res = rr_index;
    // Sequential fetches after the first use the look-ahead address instead.
    if (!s_q.table_q && code_fetch && s_q.code_vld) begin
      add_a     = s_q.la_addr; // [RQ5]
      add_a_res = mod3(s_q.la_addr);
      add_b     = ADDR_RESET;
      add_b_res = RES_RESET;
    end
  end

  // ---------------------------------------------------------------------------
  // Register file write port: restart values win, then table step, then user
  // ---------------------------------------------------------------------------
  always_comb begin
    restart_wr = RESTART && (s_q.fst == F_IDLE);
    tbl_step   = s_q.table_q && (s_q.fst == F_WAIT) && MEM_RD_ACK;
    fw_we      = AR_WE;
    fw_wa      = AR_WA;
    fw_wd      = AR_WD; // [RQ15]
    if (restart_wr) begin
      fw_we = 1'b1;
      fw_wa = base_idx(CODE_SEGMENT_BASE);
      fw_wd = RESTART_BASE; // [RQ6]
    end else if (s_q.rs_pend) begin
      fw_we = 1'b1;
      fw_wa = index_idx(CODE_OFFSET_INDEX);
      fw_wd = s_q.rs_idx; // [RQ6]
    end else if (tbl_step) begin
      fw_we = 1'b1;
      fw_wa = index_idx(TABLE_CODE_INDEX);
      fw_wd = rd_index + ADDR_ONE; // [RQ8]
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------------------
  always_comb begin
    logic exhausted;
    exhausted = 1'b0;
    s_d         = s_q;
    s_d.table_q = TABLE_MODE;
    s_d.syl_vld = 1'b0;
    s_d.ar_rd   = rd_misc;
    s_d.sum_vld = 1'b0;
    s_d.abort   = s_q.abort | add_err; // [RQ20]
    s_d.rs_pend = 1'b0;
    // Shadows of stack top and upper limit avoid a fifth read port.
    if (fw_we && fw_wa == base_idx(STACK_TOP_ADDR)) begin
      s_d.top = fw_wd;
    end
    if (fw_we && fw_wa == index_idx(STACK_UPPER_LIMIT)) begin
      s_d.lim = fw_wd;
    end
    // Growth past the limit is flagged; the stack controller must stop pushing.
    s_d.ovf     = s_q.top > s_q.lim; // [RQ16]
    s_d.frame   = rd_frame; // [RQ18]

    // Syllable issue from the current word only while it is valid.
    if (s_q.code_vld && !RESTART) begin
      s_d.syl_vld  = 1'b1; // [RQ1]
      s_d.syl_data = s_q.code_q[WORD_W-1-SYL_W*s_q.syl_ptr -: SYL_W]; // [RQ2]
    end
    if (s_q.syl_vld && SYL_TAKE && s_q.code_vld) begin
      s_d.syl_vld = 1'b0;
      if (s_q.syl_ptr == LAST_SYL) begin
        exhausted   = 1'b1;
        s_d.syl_ptr = 3'h0;
        s_d.code_vld = 1'b0;
      end else begin
        s_d.syl_ptr = s_q.syl_ptr + 3'h1; // [RQ2]
      end
    end
    if (exhausted && s_q.look_vld) begin
      s_d.code_q   = s_q.look_q; // [RQ21]
      s_d.code_vld = 1'b1;
      s_d.look_vld = 1'b0;
    end

    if (!code_fetch && s_q.fst == F_IDLE && ADDR_REQ && !RESTART) begin
      s_d.sum     = add_sum; // [RQ14]
      s_d.sum_vld = 1'b1;
    end

    unique case (s_q.fst)
      F_IDLE: begin
        if (code_fetch) begin
          s_d.req       = 1'b1;
          s_d.req_addr  = add_sum;
          s_d.dest_look = s_q.code_vld && !s_q.table_q; // [RQ4]
          s_d.la_addr   = add_sum + ADDR_ONE;
          s_d.fst       = F_FETCH;
        end
      end
      F_FETCH: begin
        s_d.req = 1'b0;
        s_d.fst = F_WAIT;
      end
      F_WAIT: begin
        if (MEM_RD_ACK) begin
          s_d.fst = F_IDLE;
          // A word meant for look-ahead goes straight to the current register
          // when the current word ran out while the read was outstanding.
          if (s_q.dest_look && !s_q.table_q && s_d.code_vld) begin
            s_d.look_q   = MEM_RD_DATA; // [RQ4]
            s_d.look_vld = 1'b1;
          end else if (!s_d.code_vld) begin
            s_d.code_q   = MEM_RD_DATA; // [RQ7]
            s_d.code_vld = 1'b1;
            s_d.syl_ptr  = s_q.restart_syl;
            s_d.restart_syl = 3'h0;
          end
        end
      end
      default: s_d.fst = F_IDLE;
    endcase

    // Table mode never keeps a look-ahead word.
    if (TABLE_MODE) begin
      s_d.look_vld = 1'b0; // [RQ7]
    end

    // A branch, entry or exit drops both words and refetches.
    if (RESTART && s_q.fst == F_IDLE) begin
      s_d.code_vld    = 1'b0; // [RQ22]
      s_d.look_vld    = 1'b0;
      s_d.syl_vld     = 1'b0;
      s_d.syl_ptr     = 3'h0;
      s_d.restart_syl = RESTART_SYL;
      s_d.rs_pend     = 1'b1;
      s_d.rs_idx      = RESTART_INDEX;
    end
    s_d.req_addr = s_d.req ? s_d.req_addr : s_q.req_addr;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q     <= '0;
      s_q.fst <= F_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign SYL_VALID       = s_q.syl_vld;
  assign SYL_DATA        = s_q.syl_data;
  assign SYL_PTR         = s_q.syl_ptr;
  assign CODE_WORD_VALID = s_q.code_vld;
  assign LOOKAHEAD_VALID = s_q.look_vld;
  assign AR_RD           = s_q.ar_rd;
  assign ADDR_SUM        = s_q.sum;
  assign ADDR_SUM_VALID  = s_q.sum_vld;
  assign STACK_OVERFLOW  = s_q.ovf;
  assign FRAME_MARKER    = s_q.frame;
  assign ABORT           = s_q.abort;
  assign MEM_RD_REQ      = s_q.req;
  assign MEM_RD_ADDR     = s_q.req_addr;
endmodule

/* File: test/prog_fetch_ctl_asserts.sv */
// Purpose: Port-level assertions for the program fetch controller.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Bound to prog_fetch_ctl after the module below.
module prog_fetch_ctl_asserts
  import prog_ctl_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       SYL_TAKE,
  input wire logic       RESTART,
  input wire logic       TABLE_MODE,
  input wire logic       MEM_RD_ACK,
  input wire logic       MEM_RD_REQ,
  input wire logic       SYL_VALID,
  input wire logic [2:0] SYL_PTR,
  input wire logic       CODE_WORD_VALID,
  input wire logic       LOOKAHEAD_VALID,
  input wire logic       ABORT
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_taken;
    SYL_VALID && SYL_TAKE && !RESTART;
  endsequence
  sequence s_last_taken;
    s_taken ##0 SYL_PTR == LAST_SYL;
  endsequence

  // Reset itself must not be masked here, so this one overrides the default.
  reset_clears_a: assert property (disable iff (1'b0) RST |=> !CODE_WORD_VALID && !LOOKAHEAD_VALID && !MEM_RD_REQ)
    else $error("flags or read request set after reset");
  syl_needs_word_a: assert property (SYL_VALID |-> CODE_WORD_VALID)
    else $error("syllable offered without a valid code word");
  ptr_steps_a: assert property (s_taken ##0 SYL_PTR != LAST_SYL |=> SYL_PTR == 3'($past(SYL_PTR) + 3'h1))
    else $error("syllable pointer did not step by one");
  word_holds_a: assert property (CODE_WORD_VALID && !SYL_TAKE && !RESTART |=> CODE_WORD_VALID && $stable(SYL_PTR))
    else $error("code word dropped or pointer moved without a take");
  promote_word_a: assert property (s_last_taken ##0 LOOKAHEAD_VALID |=> CODE_WORD_VALID && !LOOKAHEAD_VALID)
    else $error("look-ahead word not moved into current word");
  ack_loads_a: assert property (MEM_RD_ACK && !CODE_WORD_VALID && !RESTART |=> CODE_WORD_VALID)
    else $error("fetched word not valid one cycle after ack");
  // A restart is held until the fetch engine is idle; its last cycle is the one taken.
  restart_clears_a: assert property (RESTART ##1 !RESTART |-> !CODE_WORD_VALID && !LOOKAHEAD_VALID)
    else $error("valid flags not cleared by restart");
  table_no_la_a: assert property (TABLE_MODE && !LOOKAHEAD_VALID |=> !LOOKAHEAD_VALID)
    else $error("look-ahead filled in table mode");
  no_abort_a: assert property (!ABORT)
    else $error("abort raised without a residue fault");
endmodule

bind prog_fetch_ctl prog_fetch_ctl_asserts chk_u (.CLK, .RST, .SYL_TAKE, .RESTART, .TABLE_MODE, .MEM_RD_ACK,
  .MEM_RD_REQ, .SYL_VALID, .SYL_PTR, .CODE_WORD_VALID, .LOOKAHEAD_VALID, .ABORT);

/* File: test/mem_code_model.sv */
// Purpose: Memory controller model answering one code read at a time.
// Assumes: Syllable i of the word at address a is {a[4:0], i}, syllable 0 on top.
// Notes:   Read data toggles every cycle outside the ack cycle, so a late sample fails.
module mem_code_model
  import prog_ctl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [3:0]        delay,
  input  wire logic              rd_req,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic                   rd_ack,
  output logic      [WORD_W-1:0] rd_data,
  output logic                   busy,
  output logic      [ADDR_W-1:0] last_addr,
  output logic      [7:0]        n_reads
);
  logic [3:0] cnt;
  // ----------------------------------------
  // Read handling
  // ----------------------------------------
  always @(posedge clk) begin
    rd_ack <= 1'b0;
    rd_data <= ~rd_data;
    if (rst) begin
      busy <= 1'b0;
      n_reads <= 8'h00;
      rd_data <= 48'h0f0f0f0f0f0f;
    end else if (busy) begin
      if (cnt == 4'h0) begin
        rd_ack <= 1'b1;
        busy <= 1'b0;
        for (int i = 0; i < SYL_N; i++)
          rd_data[WORD_W-1-SYL_W*i -: SYL_W] <= {last_addr[4:0], 3'(i)};
      end else begin
        cnt <= cnt - 4'h1;
      end
    end else if (rd_req && !rd_ack) begin
      // A request in the ack cycle is not taken; the controller's request is a one-cycle pulse, gone before the ack.
      busy <= 1'b1;
      cnt <= delay;
      last_addr <= rd_addr;
      n_reads <= n_reads + 8'h01;
    end
  end
endmodule

/* File: test/program_fetch_address_file_tb_top.sv */
// Purpose: Self-checking bench for the program fetch controller.
// Assumes: Register file and adder answer within two cycles of a request.
// Notes:   Words are fetched from the memory model with prompt and slow acks.
module program_fetch_address_file_tb_top import prog_ctl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST, SYL_TAKE, RESTART, TABLE_MODE, AR_WE, ADDR_REQ, SYL_VALID, CODE_WORD_VALID;
  logic LOOKAHEAD_VALID, ADDR_SUM_VALID, STACK_OVERFLOW, ABORT, MEM_RD_REQ, MEM_RD_ACK, busy;
  logic [ADDR_W-1:0] RESTART_BASE, RESTART_INDEX, AR_WD, AR_RD, ADDR_SUM, FRAME_MARKER, MEM_RD_ADDR, last_addr;
  logic [IDX_W-1:0]  AR_WA, AR_RA;
  logic [2:0]        RESTART_SYL, ADDR_BASE_SEL, ADDR_INDEX_SEL, SYL_PTR;
  logic [4:0]        LEX_LEVEL;
  logic [SYL_W-1:0]  SYL_DATA;
  logic [WORD_W-1:0] MEM_RD_DATA;
  logic [7:0]        n_reads;
  logic [3:0]        delay;
  int                n_errors, num_checks;

  prog_fetch_ctl dut_u (.CLK, .RST, .SYL_TAKE, .RESTART, .RESTART_BASE, .RESTART_INDEX, .RESTART_SYL, .TABLE_MODE,
    .AR_WE, .AR_WA, .AR_WD, .AR_RA, .LEX_LEVEL, .ADDR_BASE_SEL, .ADDR_INDEX_SEL, .ADDR_REQ, .SYL_VALID, .SYL_DATA,
    .SYL_PTR, .CODE_WORD_VALID, .LOOKAHEAD_VALID, .AR_RD, .ADDR_SUM, .ADDR_SUM_VALID, .STACK_OVERFLOW,
    .FRAME_MARKER, .ABORT, .MEM_RD_REQ, .MEM_RD_ADDR, .MEM_RD_ACK, .MEM_RD_DATA);
  mem_code_model mem_u (.clk(CLK), .rst(RST), .delay, .rd_req(MEM_RD_REQ), .rd_addr(MEM_RD_ADDR),
    .rd_ack(MEM_RD_ACK), .rd_data(MEM_RD_DATA), .busy, .last_addr, .n_reads);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always #12.5 CLK = ~CLK;

  function automatic logic [ADDR_W-1:0] rv(input int i);
    return 20'(i * 1041 + 32);
  endfunction

  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic ar_write(input int i, input logic [ADDR_W-1:0] v);
    @(posedge CLK) {AR_WE, AR_WA, AR_WD} <= {1'b1, 6'(i), v};
    @(posedge CLK) AR_WE <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
  endtask

  task automatic restart(input logic [ADDR_W-1:0] b, x, input logic [2:0] s, input logic [ADDR_W-1:0] ea);
    int k;
    logic [7:0] n0;
    // Restart is refused while a read is outstanding, so hold it until idle.
    @(posedge CLK) {RESTART, RESTART_BASE, RESTART_INDEX, RESTART_SYL} <= {1'b1, b, x, s};
    @(negedge CLK);
    for (k = 0; k < 200 && (MEM_RD_REQ || busy || MEM_RD_ACK); k++) @(negedge CLK);
    @(posedge CLK) RESTART <= 1'b0;
    n0 = n_reads;
    @(negedge CLK);
    check(48'({CODE_WORD_VALID, LOOKAHEAD_VALID}), 48'h0);
    for (k = 0; k < 200 && n_reads == n0; k++) @(negedge CLK);
    check(48'(last_addr), 48'(ea));
  endtask

  task automatic consume(input logic [ADDR_W-1:0] a, input logic [2:0] p, input int n);
    int k;
    @(posedge CLK) SYL_TAKE <= 1'b1;
    repeat (n) begin
      @(negedge CLK);
      for (k = 0; k < 200 && SYL_VALID !== 1'b1; k++) @(negedge CLK);
      check(48'({SYL_DATA, SYL_PTR}), 48'({a[4:0], p, p}));
      check(48'(LOOKAHEAD_VALID & TABLE_MODE), 48'h0);
      if (p == LAST_SYL) {a, p} = {a + ADDR_ONE, 3'h0};
      else p++;
      @(posedge CLK);
    end
    SYL_TAKE <= 1'b0;
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #(25ns * 30000);
    n_errors++;
    summarize();
  end

  initial begin
    {CLK, RST, SYL_TAKE, RESTART, TABLE_MODE, AR_WE, ADDR_REQ} = 7'b0100000;
    {RESTART_BASE, RESTART_INDEX, AR_WD, AR_WA, AR_RA, RESTART_SYL} = '0;
    {ADDR_BASE_SEL, ADDR_INDEX_SEL, LEX_LEVEL, delay} = '0;
    settle(10);
    check(48'({CODE_WORD_VALID, LOOKAHEAD_VALID, SYL_VALID, MEM_RD_REQ, ABORT, STACK_OVERFLOW}), 48'h0);
    @(posedge CLK) RST <= 1'b0;
    for (int i = 0; i < REG_N; i++) ar_write(i, rv(i));
    for (int i = 0; i < REG_N; i++) begin
      @(posedge CLK) AR_RA <= 6'(i);
      settle(2);
      check(48'(AR_RD), 48'(rv(i)));
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge CLK) {ADDR_REQ, ADDR_BASE_SEL, ADDR_INDEX_SEL} <= {1'b1, 3'(k), 3'(k)};
      @(posedge CLK) ADDR_REQ <= 1'b0;
      @(negedge CLK);
      check(48'(ADDR_SUM_VALID), 48'h1);
      check(48'(ADDR_SUM), 48'(rv(32 + k) + rv(40 + k)));
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge CLK) LEX_LEVEL <= 5'(i == 0 ? 2 : i == 1 ? 17 : 31);
      settle(2);
      check(48'(FRAME_MARKER), 48'(rv(i == 0 ? 2 : i == 1 ? 17 : 31)));
    end
    ar_write(36, rv(44) + ADDR_ONE);
    settle(2);
    check(48'(STACK_OVERFLOW), 48'h1);
    ar_write(36, rv(44) - ADDR_ONE);
    settle(2);
    check(48'(STACK_OVERFLOW), 48'h0);
    delay <= 4'h3;
    restart(20'h00100, 20'h00010, 3'h3, 20'h00110);
    consume(20'h00110, 3'h3, 15);
    delay <= 4'h0;
    settle(20);
    check(48'({CODE_WORD_VALID, LOOKAHEAD_VALID}), 48'h3);
    restart(20'h00200, 20'h00007, 3'h0, 20'h00207);
    consume(20'h00207, 3'h0, 14);
    ar_write(35, 20'h00300);
    ar_write(43, 20'h00005);
    @(posedge CLK) TABLE_MODE <= 1'b1;
    restart(20'h00900, 20'h00000, 3'h0, 20'h00305);
    consume(20'h00305, 3'h0, 12);
    @(posedge CLK) TABLE_MODE <= 1'b0;
    summarize();
  end
endmodule
